//--- i2sp_pkg.sv
// Package: register map, field layouts, reset values and divider figures
package i2sp_pkg;

    localparam int          AXI_AW             = 18;
    localparam int          AXI_DW             = 32;

    // Register indices; byte address is four times the index
    localparam logic [15:0] PRESCALER_MODE_IDX = 16'hffb2;
    localparam logic [15:0] BUS_STATUS_IDX     = 16'hffa0;
    localparam logic [15:0] BUS_CONTROL_IDX    = 16'hffa1;

    localparam logic [7:0]  PRESCALER_MODE_RST = 8'h00;
    localparam logic [7:0]  BUS_STATUS_RST     = 8'h00;
    localparam logic [7:0]  BUS_CONTROL_RST    = 8'h00;

    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    // Bus control field positions
    localparam int          CTL_UNIT_EN_BIT    = 7;
    localparam int          CTL_BUS_REL_BIT    = 6;
    localparam int          CTL_WAIT_REL_BIT   = 5;
    localparam int          CTL_CLK_DRIVE_BIT  = 4;
    localparam int          CTL_TX_SET_BIT     = 3;
    localparam int          CTL_DATA_OUT_BIT   = 0;

    // Transfer clock divide ratios
    localparam logic [7:0]  DIV_NORMAL_00      = 8'h2c;
    localparam logic [7:0]  DIV_NORMAL_01      = 8'h56;
    localparam logic [7:0]  DIV_NORMAL_10      = 8'hac;
    localparam logic [7:0]  DIV_NORMAL_TMR     = 8'h42;
    localparam logic [7:0]  DIV_FAST_0X        = 8'h18;
    localparam logic [7:0]  DIV_FAST_10        = 8'h30;
    localparam logic [7:0]  DIV_FAST_TMR       = 8'h12;

    // Serial clock counts within a byte
    localparam logic [3:0]  CLK_NONE           = 4'h0;
    localparam logic [3:0]  CLK_EIGHTH         = 4'h8;
    localparam logic [3:0]  CLK_NINTH          = 4'h9;
    localparam logic [3:0]  CLK_FIRST          = 4'h1;

    // Input filter: cycles a new level must persist
    localparam logic [2:0]  FILTER_CYCLES      = 3'h4;

    typedef struct packed {
        logic [1:0] zero;
        logic       clock_level_monitor;
        logic       data_level_monitor;
        logic       speed_mode_select;
        logic       filter_enable;
        logic       divider_select_hi;
        logic       divider_select_lo;
    } i2sp_prescaler_t;

    typedef struct packed {
        logic [3:0] zero;
        logic       transmit_state_flag;
        logic       ack_detected_flag;
        logic       start_detected_flag;
        logic       stop_detected_flag;
    } i2sp_flags_t;

    typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH} i2sp_scl_state_t;

endpackage

//--- i2sp_sync.sv
// Two-flop synchroniser for line inputs
`timescale 1ns/10ps
module i2sp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // Idle bus lines are high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

//--- i2sp_top.sv
// Two-wire bus status flags, prescaler register and transfer clock divider
//
// Function
// - Wait release clears transmit flag, floats data
// - Ack flag set on low ninth-clock data
// - Ack cleared: stop, next byte, release, disable
// - Start flag set on detected start
// - Start cleared: stop, post-address byte, release, disable
// - Stop flag set on detected stop
// - Stop flag holds until next address byte or disable
// - Prescaler resets to zero, only bits 3:0 writable
// - Monitor bits read-only, bits 7:6 zero
// - Clock monitor shows line, zero when disabled
// - Data monitor shows line, zero when disabled
// - Speed bit picks normal or fast table
// - Normal divides 44, 86, 172, timer 66
// - Fast divides 24, 24, 48, timer 18
// - Filter bit never changes divider
// - Filter bit switches input filter
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module i2sp_top
    import i2sp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [AXI_DW-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_clock_pin_in,
    output logic                   serial_clock_pin_out,
    output logic                   serial_clock_pin_oe_n,
    input  wire logic              serial_data_pin_in,
    output logic                   serial_data_pin_out,
    output logic                   serial_data_pin_oe_n,
    input  wire logic              timer_source
);
    logic            scl_s;
    logic            sda_s;
    // Register bus state
    logic            awready_reg, awready_next, wready_reg, wready_next;
    logic            aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [15:0]     waddr_reg, waddr_next;
    logic [7:0]      wdata_reg, wdata_next;
    logic            wstrb_reg, wstrb_next;
    logic            bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic            rvalid_reg, rvalid_next;
    logic [1:0]      bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [7:0]      rdata_reg, rdata_next;
    logic            do_wr, wr_pm, wr_ctl, wr_hit;
    logic [15:0]     raddr;
    // Registers
    i2sp_prescaler_t pm_reg, pm_next, pm_view;
    logic [7:0]      ctl_reg, ctl_next;
    i2sp_flags_t     flags_reg, flags_next;
    logic            unit_en, rel_pulse, wrel_pulse, txset_pulse;
    // Line conditioning and bus monitor
    logic [1:0]      line_reg, line_next, line_q_reg, line_q_next;
    logic [2:0]      filt_cnt_reg [2];
    logic [2:0]      filt_cnt_next [2];
    logic [1:0]      raw_line;
    logic [3:0]      bit_cnt_reg, bit_cnt_next;
    logic            addr_byte_reg, addr_byte_next, en_q_reg, en_q_next;
    logic            scl_rise, start_ev, stop_ev, en_fall, first_clk, ninth_clk;
    logic            ack_set, ack_clr, std_clr, spd_clr, tx_clr;
    // Transfer clock divider
    i2sp_scl_state_t scl_state_reg, scl_state_next;
    logic [7:0]      div_cnt_reg, div_cnt_next, div_ratio, div_half;
    logic            use_tmr, div_tick;
    logic            scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;

    i2sp_sync #(.WIDTH(2)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({serial_clock_pin_in, serial_data_pin_in}),
        .sync_out ({scl_s, sda_s})
    );

    // Register bus slave
    assign raddr  = s_axi_araddr[AXI_AW-1:2];
    assign do_wr  = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_pm  = do_wr && wstrb_reg && (waddr_reg == PRESCALER_MODE_IDX);
    assign wr_ctl = do_wr && wstrb_reg && (waddr_reg == BUS_CONTROL_IDX);
    assign wr_hit = (waddr_reg == PRESCALER_MODE_IDX) || (waddr_reg == BUS_CONTROL_IDX)
                    || (waddr_reg == BUS_STATUS_IDX);

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            waddr_next   = s_axi_awaddr[AXI_AW-1:2];
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata[7:0];
            wstrb_next  = s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            if (raddr == PRESCALER_MODE_IDX) begin
                rdata_next = pm_view;
            end else if (raddr == BUS_STATUS_IDX) begin
                rdata_next = flags_reg;
            end else if (raddr == BUS_CONTROL_IDX) begin
                rdata_next = ctl_reg;
            end else begin
                rdata_next = 8'h00;
                rresp_next = RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        awready_next = !aw_held_next && !bvalid_next;
        wready_next  = !w_held_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            waddr_reg   <= 16'h0000;
            wdata_reg   <= 8'h00;
            wstrb_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 8'h00;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = {24'h00_0000, rdata_reg};

    // Control and prescaler registers
    assign unit_en     = ctl_reg[CTL_UNIT_EN_BIT];
    assign rel_pulse   = wr_ctl && wdata_reg[CTL_BUS_REL_BIT];
    assign wrel_pulse  = wr_ctl && wdata_reg[CTL_WAIT_REL_BIT];
    assign txset_pulse = wr_ctl && wdata_reg[CTL_TX_SET_BIT];

    always_comb begin
        pm_view                     = pm_reg;
        pm_view.zero                = 2'b00;
        pm_view.clock_level_monitor = unit_en && scl_s;
        pm_view.data_level_monitor  = unit_en && sda_s;
    end

    always_comb begin
        pm_next  = pm_reg;
        ctl_next = ctl_reg;
        if (wr_pm) begin
            pm_next       = wdata_reg;
            pm_next[7:4]  = 4'h0;
        end
        if (wr_ctl) begin
            ctl_next                    = 8'h00;
            ctl_next[CTL_UNIT_EN_BIT]   = wdata_reg[CTL_UNIT_EN_BIT];
            ctl_next[CTL_CLK_DRIVE_BIT] = wdata_reg[CTL_CLK_DRIVE_BIT];
            ctl_next[CTL_DATA_OUT_BIT]  = wdata_reg[CTL_DATA_OUT_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pm_reg  <= PRESCALER_MODE_RST;
            ctl_reg <= BUS_CONTROL_RST;
        end else begin
            pm_reg  <= pm_next;
            ctl_reg <= ctl_next;
        end
    end

    // Input filter and bus condition monitor
    assign raw_line  = {scl_s, sda_s};
    assign scl_rise  = unit_en && line_reg[1] && !line_q_reg[1];
    assign start_ev  = unit_en && line_reg[1] && line_q_reg[1] && !line_reg[0] && line_q_reg[0];
    assign stop_ev   = unit_en && line_reg[1] && line_q_reg[1] && line_reg[0] && !line_q_reg[0];
    assign en_fall   = en_q_reg && !unit_en;
    assign first_clk = scl_rise && ((bit_cnt_reg == CLK_NINTH) || (bit_cnt_reg == CLK_NONE));
    assign ninth_clk = scl_rise && (bit_cnt_reg == CLK_EIGHTH);
    assign ack_set   = ninth_clk && !line_reg[0];
    assign ack_clr   = stop_ev || first_clk || rel_pulse || en_fall;
    assign std_clr   = stop_ev || (first_clk && addr_byte_reg && bit_cnt_reg == CLK_NINTH)
                       || rel_pulse || en_fall;
    assign spd_clr   = (first_clk && addr_byte_reg && bit_cnt_reg == CLK_NONE) || en_fall;
    assign tx_clr    = wrel_pulse || rel_pulse || en_fall || stop_ev;

    always_comb begin
        line_next      = line_reg;
        line_q_next    = line_reg;
        bit_cnt_next   = bit_cnt_reg;
        addr_byte_next = addr_byte_reg;
        en_q_next      = unit_en;
        flags_next     = flags_reg;
        for (int i = 0; i < 2; i++) begin
            filt_cnt_next[i] = 3'h0;
            if (!pm_reg.filter_enable) begin
                line_next[i] = raw_line[i];
            end else if (raw_line[i] != line_reg[i]) begin
                filt_cnt_next[i] = filt_cnt_reg[i] + 3'h1;
                if (filt_cnt_reg[i] == FILTER_CYCLES - 3'h1) begin
                    line_next[i]     = raw_line[i];
                    filt_cnt_next[i] = 3'h0;
                end
            end
        end
        if (!unit_en || stop_ev) begin
            bit_cnt_next   = CLK_NONE;
            addr_byte_next = 1'b0;
        end else if (start_ev) begin
            bit_cnt_next   = CLK_NONE;
            addr_byte_next = 1'b1;
        end else if (scl_rise) begin
            bit_cnt_next = (bit_cnt_reg == CLK_NINTH) ? CLK_FIRST : bit_cnt_reg + CLK_FIRST;
            if (bit_cnt_reg == CLK_NINTH) begin
                addr_byte_next = 1'b0;
            end
        end
        // Clears first so that a coincident set wins
        if (ack_clr) flags_next.ack_detected_flag = 1'b0;
        if (std_clr) flags_next.start_detected_flag = 1'b0;
        if (spd_clr) flags_next.stop_detected_flag = 1'b0;
        if (tx_clr) flags_next.transmit_state_flag = 1'b0;
        if (ack_set) flags_next.ack_detected_flag = 1'b1;
        if (start_ev) flags_next.start_detected_flag = 1'b1;
        if (stop_ev) flags_next.stop_detected_flag = 1'b1;
        if (txset_pulse && unit_en) flags_next.transmit_state_flag = 1'b1;
        flags_next.zero = 4'h0;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            line_reg      <= 2'b11;
            line_q_reg    <= 2'b11;
            filt_cnt_reg  <= '{3'h0, 3'h0};
            bit_cnt_reg   <= CLK_NONE;
            addr_byte_reg <= 1'b0;
            en_q_reg      <= 1'b0;
            flags_reg     <= BUS_STATUS_RST;
        end else begin
            line_reg      <= line_next;
            line_q_reg    <= line_q_next;
            filt_cnt_reg  <= filt_cnt_next;
            bit_cnt_reg   <= bit_cnt_next;
            addr_byte_reg <= addr_byte_next;
            en_q_reg      <= en_q_next;
            flags_reg     <= flags_next;
        end
    end

    // Transfer clock divider; filter bit deliberately not decoded
    always_comb begin
        use_tmr   = 1'b0;
        div_ratio = DIV_NORMAL_00;
        case ({pm_reg.speed_mode_select, pm_reg.divider_select_hi,
               pm_reg.divider_select_lo})
            3'b000:  div_ratio = DIV_NORMAL_00;
            3'b001:  div_ratio = DIV_NORMAL_01;
            3'b010:  div_ratio = DIV_NORMAL_10;
            3'b011: begin
                div_ratio = DIV_NORMAL_TMR;
                use_tmr   = 1'b1;
            end
            3'b100, 3'b101: div_ratio = DIV_FAST_0X;
            3'b110:  div_ratio = DIV_FAST_10;
            3'b111: begin
                div_ratio = DIV_FAST_TMR;
                use_tmr   = 1'b1;
            end
            default: div_ratio = DIV_NORMAL_00;
        endcase
    end

    assign div_half = {1'b0, div_ratio[7:1]} - 8'h01;
    assign div_tick = use_tmr ? timer_source : 1'b1;

    always_comb begin
        scl_state_next = scl_state_reg;
        div_cnt_next   = div_cnt_reg;
        case (scl_state_reg)
            SCL_IDLE: begin
                div_cnt_next = div_half;
                if (unit_en && ctl_reg[CTL_CLK_DRIVE_BIT]) scl_state_next = SCL_LOW;
            end
            SCL_LOW: begin
                if (div_tick) begin
                    div_cnt_next = div_cnt_reg - 8'h01;
                    if (div_cnt_reg == 8'h00) begin
                        div_cnt_next   = div_half;
                        scl_state_next = SCL_HIGH;
                    end
                end
            end
            SCL_HIGH: begin
                if (div_tick && line_reg[1]) begin
                    div_cnt_next = div_cnt_reg - 8'h01;
                    if (div_cnt_reg == 8'h00) begin
                        div_cnt_next   = div_half;
                        scl_state_next = SCL_LOW;
                    end
                end
            end
            default: scl_state_next = SCL_IDLE;
        endcase
        if (!unit_en || !ctl_reg[CTL_CLK_DRIVE_BIT]) scl_state_next = SCL_IDLE;
        scl_oe_n_next = (scl_state_next != SCL_LOW);
        sda_oe_n_next = !(flags_next.transmit_state_flag && unit_en
                          && !ctl_reg[CTL_DATA_OUT_BIT]);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_state_reg <= SCL_IDLE;
            div_cnt_reg   <= 8'h00;
            scl_oe_n_reg  <= 1'b1;
            sda_oe_n_reg  <= 1'b1;
        end else begin
            scl_state_reg <= scl_state_next;
            div_cnt_reg   <= div_cnt_next;
            scl_oe_n_reg  <= scl_oe_n_next;
            sda_oe_n_reg  <= sda_oe_n_next;
        end
    end

    assign serial_clock_pin_oe_n = scl_oe_n_reg;
    assign serial_data_pin_oe_n  = sda_oe_n_reg;
    assign serial_clock_pin_out  = 1'b0;
    assign serial_data_pin_out   = 1'b0;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_tx_release;
        !flags_reg.transmit_state_flag ##1 sda_oe_n_reg;
    endsequence

    AST_WREL_FLOATS: assert property (wrel_pulse && flags_reg.transmit_state_flag && !txset_pulse
        |=> s_tx_release) else $error("wait release left transmit state");
    AST_ACK_SET: assert property (ninth_clk && !line_reg[0] && !rel_pulse && !en_fall
        |=> flags_reg.ack_detected_flag) else $error("ack not flagged");
    AST_ACK_CLEAR: assert property ((stop_ev || first_clk || en_fall) && !ack_set
        |=> !flags_reg.ack_detected_flag) else $error("ack not cleared");
    AST_START_SET: assert property (start_ev
        |=> flags_reg.start_detected_flag) else $error("start not flagged");
    AST_START_CLEAR: assert property ((stop_ev || en_fall) && !start_ev
        |=> !flags_reg.start_detected_flag) else $error("start not cleared");
    AST_STOP_SET: assert property (stop_ev
        |=> flags_reg.stop_detected_flag) else $error("stop not flagged");
    AST_STOP_HOLDS: assert property (flags_reg.stop_detected_flag && !scl_rise && !en_fall
        |=> flags_reg.stop_detected_flag) else $error("stop flag dropped");
    AST_CLK_MON_OFF: assert property (s_axi_arvalid && arready_reg && !unit_en
        && raddr == PRESCALER_MODE_IDX |=> rvalid_reg && rdata_reg[7:4] == 4'h0)
        else $error("monitor bits not zero while disabled");
    AST_SCL_LOW_PHASE: assert property ($rose(!scl_oe_n_reg) && !use_tmr
        |-> !scl_oe_n_reg [*8]) else $error("low phase too short");
endmodule

//--- i2sp_peer.sv
// Bus peer model: another master driving the two-wire lines open-drain
`timescale 1ns/10ps
module i2sp_peer (
    input  wire logic core_clk,
    output logic      scl_low,
    output logic      sda_low
);
    // Half bit time keeps the bus clock at 100 kHz
    localparam int HALF = 500;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(posedge core_clk);
    endtask
    task automatic start_c();
        sda_low <= 1'b1;
        hold();
        scl_low <= 1'b1;
        hold();
    endtask
    // Data changes only while the clock is low
    task automatic bit_c(input logic b);
        sda_low <= !b;
        hold();
        scl_low <= 1'b0;
        hold();
        scl_low <= 1'b1;
    endtask
    task automatic stop_c();
        sda_low <= 1'b1;
        hold();
        scl_low <= 1'b0;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask
endmodule

//--- test_i2c_status_and_clock_prescaler.sv
// Testbench: register access, flag sequencing and divider checks
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module test_i2c_status_and_clock_prescaler;
    import i2sp_pkg::*;
    logic              core_clk = 1'b0;
    logic              rstn = 1'b0;
    logic [AXI_AW-1:0] awa = '0, ara = '0;
    logic [AXI_DW-1:0] wd = '0, rdat;
    logic [3:0]        ws = '0;
    logic [1:0]        br, rr;
    logic              awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, tmr = 0;
    logic              awr, wrd, bv, arr, rv, scl_oe_n, scl_o, sda_oe_n, sda_o, scl_low, sda_low;
    int                error_cnt = 0, comparisons = 0, n;
    int                ex[8] = '{44, 86, 172, 132, 24, 24, 48, 36};
    logic [7:0]        d;
    logic [1:0]        r;
    wire               scl_line = !scl_low && (scl_oe_n || scl_o);
    wire               sda_line = !sda_low && (sda_oe_n || sda_o);

    i2sp_top u_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .timer_source(tmr),
        .serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_o),
        .serial_clock_pin_oe_n(scl_oe_n), .serial_data_pin_in(sda_line),
        .serial_data_pin_out(sda_o), .serial_data_pin_oe_n(sda_oe_n));
    i2sp_peer u_peer (.core_clk(core_clk), .scl_low(scl_low), .sda_low(sda_low));

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        tmr <= ~tmr;
    end

    task automatic bus_wr(input logic [15:0] idx, input logic [7:0] v);
        @(posedge core_clk);
        awa <= {idx, 2'b00};
        wd <= {24'h00_0000, v};
        ws <= 4'h1;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrd) wv <= 1'b0;
        end while (bv !== 1'b1);
        brd <= 1'b0;
    endtask
    task automatic bus_rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] s);
        @(posedge core_clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rrd <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        v = rdat[7:0];
        s = rr;
        rrd <= 1'b0;
    endtask
    task automatic expect_reg(input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] v;
        logic [1:0] s;
        bus_rd(idx, v, s);
        `CHK(v, e)
        `CHK(s, RESP_OKAY)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #500_000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        expect_reg(PRESCALER_MODE_IDX, 8'h00);
        expect_reg(BUS_STATUS_IDX, 8'h00);
        bus_wr(PRESCALER_MODE_IDX, 8'hff);
        expect_reg(PRESCALER_MODE_IDX, 8'h0f);
        bus_wr(BUS_CONTROL_IDX, 8'h80);
        expect_reg(PRESCALER_MODE_IDX, 8'h3f);
        $display("test registers done");
        u_peer.start_c();
        expect_reg(PRESCALER_MODE_IDX, 8'h0f);
        expect_reg(BUS_STATUS_IDX, 8'h02);
        for (int i = 0; i < 9; i++) u_peer.bit_c(1'b0);
        expect_reg(BUS_STATUS_IDX, 8'h06);
        u_peer.bit_c(1'b1);
        expect_reg(BUS_STATUS_IDX, 8'h00);
        u_peer.stop_c();
        expect_reg(BUS_STATUS_IDX, 8'h01);
        u_peer.start_c();
        expect_reg(BUS_STATUS_IDX, 8'h03);
        u_peer.bit_c(1'b0);
        expect_reg(BUS_STATUS_IDX, 8'h02);
        bus_wr(BUS_CONTROL_IDX, 8'hc0);
        expect_reg(BUS_STATUS_IDX, 8'h00);
        u_peer.stop_c();
        u_peer.start_c();
        expect_reg(BUS_STATUS_IDX, 8'h03);
        bus_wr(BUS_CONTROL_IDX, 8'h00);
        expect_reg(BUS_STATUS_IDX, 8'h00);
        u_peer.stop_c();
        $display("test flags done");
        // Peer holds both lines low so the driven data line makes no start
        u_peer.start_c();
        bus_wr(BUS_CONTROL_IDX, 8'h80);
        bus_wr(BUS_CONTROL_IDX, 8'h88);
        expect_reg(BUS_STATUS_IDX, 8'h08);
        `CHK(sda_oe_n, 1'b0)
        bus_wr(BUS_CONTROL_IDX, 8'ha0);
        expect_reg(BUS_STATUS_IDX, 8'h00);
        `CHK(sda_oe_n, 1'b1)
        bus_rd(16'h0000, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 8'h00)
        // Free both lines so the divider sees its clock go high
        u_peer.stop_c();
        $display("test wait release done");
        for (int i = 0; i < 8; i++) begin
            bus_wr(BUS_CONTROL_IDX, 8'h00);
            bus_wr(PRESCALER_MODE_IDX, {4'h0, i[2], i[0], i[1:0]});
            bus_wr(BUS_CONTROL_IDX, 8'h90);
            n = 0;
            while (scl_oe_n !== 1'b0) @(posedge core_clk);
            do begin @(posedge core_clk); n++; end while (scl_oe_n === 1'b0);
            do begin @(posedge core_clk); n++; end while (scl_oe_n !== 1'b0);
            `CHK(n >= ex[i] && n <= ex[i] + 12, 1'b1)
            // Let the low phase finish before the unit is switched off
            while (scl_oe_n === 1'b0) @(posedge core_clk);
        end
        bus_wr(BUS_CONTROL_IDX, 8'h00);
        $display("test divider done");
        summarize();
    end
endmodule
